// ---- hdl/pmxcb_bank.sv ----
// per-port media and switch mac configuration bank with apb slave
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
// Functional notes
// - duplex bit: one gives full duplex, zero half; resets to one
// - transmit flow control enable bit turns transmit flow control on or off
// - receive flow control enable bit turns receive flow control on or off
// - both flow control enables reset from the flow control strap
// - ten-or-hundred bit ignored at gigabit; one 100, zero 10; resets one
// - gigabit select: zero gives 1000, one defers; port 6 resets from strap
// - ingress delay bit adds at least 1.5 ns on receive clock; resets zero
// - egress delay bit adds at least 1.5 ns on transmit clock; resets one
// - in mii, role one acts as mac taking clocks; zero acts phy driving them
// - in rmii, role one receives 50 MHz reference; zero drives it out
// - type field: 00 rgmii, 01 rmii, 1x mii; port 6 strap, port 7 zero
// - storm protection bit enables broadcast storm protection on ingress
// - back pressure applies only at half duplex; pause governed separately
// - bad frames dropped; pass-all forwards them to mirror ports only
// - pass-all leaves flow control frame filtering to the switch setting
module pmxcb_bank
    import pmxcb_pkg::*;
#(
    parameter int PORT_NUM = 6,
    parameter int ADDR_W = 14
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic flow_control_strap,
    input wire logic speed_strap,
    input wire logic clock_role_strap,
    input wire logic [1:0] interface_type_strap,
    input wire logic frame_end,
    input wire logic frame_bad,
    input wire logic frame_is_fc,
    input wire logic fc_filter_en,
    output logic duplex_full,
    output logic tx_flow_ctrl_en,
    output logic rx_flow_ctrl_en,
    output logic [1:0] speed_code,
    output logic [1:0] interface_type,
    output logic mii_mac_role,
    output logic mii_drive_clocks,
    output logic rmii_refclk_drive,
    output logic rx_clock_delay_enable,
    output logic tx_clock_delay_enable,
    output logic storm_protect_en,
    output logic backpress_active,
    output logic verdict_valid,
    output logic fwd_normal,
    output logic fwd_mirror_only,
    output logic frame_drop
);
    ////////////////////////////////////////////////////////////////////////////
    // register storage
    logic [7:0] setup_a_r;
    logic [7:0] setup_b_r;
    logic [7:0] opt_a_r;
    logic [7:0] opt_b_r;
    logic [7:0] setup_a_nxt;
    logic [7:0] setup_b_nxt;
    logic [7:0] opt_a_nxt;
    logic [7:0] opt_b_nxt;
    logic [7:0] setup_a_rst;
    logic [7:0] setup_b_rst;
    logic [7:0] rd_byte;
    logic hit_setup_a;
    logic hit_setup_b;
    logic hit_opt_a;
    logic hit_opt_b;
    logic hit_any;
    logic wr_commit;
    logic [ADDR_W-1:0] addr_a;
    logic [ADDR_W-1:0] addr_b;
    logic [ADDR_W-1:0] addr_c;
    logic [ADDR_W-1:0] addr_d;
    logic pready_r;
    logic pslverr_r;
    logic [31:0] prdata_r;
    logic tx_fc_r;
    logic rx_fc_r;
    logic storm_r;

    localparam logic PORT7_ID = (PORT_NUM == 7);

    assign addr_a = ADDR_W'(ADDR_SETUP_A);
    assign addr_b = ADDR_W'(ADDR_SETUP_B);
    assign addr_c = ADDR_W'(ADDR_OPT_A);
    assign addr_d = ADDR_W'(ADDR_OPT_B);

    ////////////////////////////////////////////////////////////////////////////
    // address decode
    always_comb begin
        hit_setup_a = 1'b0;
        hit_setup_b = 1'b0;
        hit_opt_a = 1'b0;
        hit_opt_b = 1'b0;
        if (paddr == addr_a) begin
            hit_setup_a = 1'b1;
        end else if (paddr == addr_b) begin
            hit_setup_b = 1'b1;
        end else if (paddr == addr_c) begin
            hit_opt_a = 1'b1;
        end else if (paddr == addr_d) begin
            hit_opt_b = 1'b1;
        end
    end
    assign hit_any = hit_setup_a | hit_setup_b | hit_opt_a | hit_opt_b;

    // one wait state: the write lands at the edge where pready is seen high
    assign wr_commit = psel && penable && pready_r && pwrite && pstrb[0] && hit_any;

    ////////////////////////////////////////////////////////////////////////////
    // reset values; strap levels are loaded while the synchronous reset holds
    always_comb begin
        setup_a_rst = RST_SETUP_A;
        setup_a_rst[SA_PORT7_ID] = PORT7_ID;
        setup_a_rst[SA_TX_FC] = flow_control_strap;
        setup_a_rst[SA_RX_FC] = flow_control_strap;
        setup_b_rst = RST_SETUP_B;
        if (!PORT7_ID) begin
            setup_b_rst[SB_NOT_GIG] = speed_strap;
            setup_b_rst[SB_ROLE] = clock_role_strap;
            setup_b_rst[SB_ITYPE_HI:SB_ITYPE_LO] = interface_type_strap;
        end
    end

    // masked merge keeps read-only reserved bits at their fixed values
    always_comb begin
        setup_a_nxt = (setup_a_r & ~MASK_SETUP_A) | (pwdata[7:0] & MASK_SETUP_A);
        setup_b_nxt = (setup_b_r & ~MASK_SETUP_B) | (pwdata[7:0] & MASK_SETUP_B);
        opt_a_nxt = (opt_a_r & ~MASK_OPT_A) | (pwdata[7:0] & MASK_OPT_A);
        opt_b_nxt = (opt_b_r & ~MASK_OPT_B) | (pwdata[7:0] & MASK_OPT_B);
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            setup_a_r <= setup_a_rst;
            setup_b_r <= setup_b_rst;
            opt_a_r <= RST_OPT_A;
            opt_b_r <= RST_OPT_B;
        end else if (wr_commit) begin
            if (hit_setup_a) begin
                setup_a_r <= setup_a_nxt;
            end
            if (hit_setup_b) begin
                setup_b_r <= setup_b_nxt;
            end
            if (hit_opt_a) begin
                opt_a_r <= opt_a_nxt;
            end
            if (hit_opt_b) begin
                opt_b_r <= opt_b_nxt;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // apb answer
    always_comb begin
        rd_byte = 8'h00;
        if (hit_setup_a) begin
            rd_byte = setup_a_r;
        end else if (hit_setup_b) begin
            rd_byte = setup_b_r;
        end else if (hit_opt_a) begin
            rd_byte = opt_a_r;
        end else if (hit_opt_b) begin
            rd_byte = opt_b_r;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else if (psel && penable && !pready_r) begin
            pready_r <= 1'b1;
            pslverr_r <= !hit_any;
            prdata_r <= {24'h00_0000, pwrite ? 8'h00 : rd_byte};
        end else begin
            // answer lasts one cycle; a stale pslverr must not leak forward
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end
    end
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign prdata = prdata_r;

    ////////////////////////////////////////////////////////////////////////////
    // flow control and storm enables
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            tx_fc_r <= 1'b0;
            rx_fc_r <= 1'b0;
            storm_r <= 1'b0;
        end else begin
            tx_fc_r <= setup_a_r[SA_TX_FC];
            rx_fc_r <= setup_a_r[SA_RX_FC];
            storm_r <= opt_a_r[OA_STORM];
        end
    end
    assign tx_flow_ctrl_en = tx_fc_r;
    assign rx_flow_ctrl_en = rx_fc_r;
    assign storm_protect_en = storm_r;

    ////////////////////////////////////////////////////////////////////////////
    // submodules
    pmxcb_mode u_mode (
        .clk_sys(clk_sys),
        .srst(srst),
        .setup_a(setup_a_r),
        .setup_b(setup_b_r),
        .opt_b(opt_b_r),
        .speed_code_r(speed_code),
        .duplex_full_r(duplex_full),
        .backpress_active_r(backpress_active),
        .interface_type_r(interface_type),
        .mii_mac_role_r(mii_mac_role),
        .mii_drive_clocks_r(mii_drive_clocks),
        .rmii_refclk_drive_r(rmii_refclk_drive),
        .rx_clock_delay_enable_r(rx_clock_delay_enable),
        .tx_clock_delay_enable_r(tx_clock_delay_enable)
    );

    pmxcb_verdict u_verdict (
        .clk_sys(clk_sys),
        .srst(srst),
        .frame_end(frame_end),
        .frame_bad(frame_bad),
        .frame_is_fc(frame_is_fc),
        .fc_filter_en(fc_filter_en),
        .pass_all(opt_b_r[OB_PASS_ALL]),
        .verdict_valid_r(verdict_valid),
        .fwd_normal_r(fwd_normal),
        .fwd_mirror_only_r(fwd_mirror_only),
        .drop_r(frame_drop)
    );

    ////////////////////////////////////////////////////////////////////////////
    // assertions
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (srst);

    property p_duplex;
        !srst && !wr_commit |=> ##1 duplex_full == $past(setup_a_r[SA_DUPLEX], 2);
    endproperty
    a_duplex: assert property (p_duplex) else $error("duplex output mismatch");

    property p_txfc;
        !$past(wr_commit) && !$past(srst) |-> ##1 tx_flow_ctrl_en == $past(setup_a_r[SA_TX_FC]);
    endproperty
    a_txfc: assert property (p_txfc) else $error("tx flow control mismatch");

    property p_rxfc;
        !srst && setup_a_r[SA_RX_FC] && !wr_commit |-> ##1 rx_flow_ctrl_en;
    endproperty
    a_rxfc: assert property (p_rxfc) else $error("rx flow control not on");

    property p_strap;
        $fell(srst) |-> setup_a_r[SA_TX_FC] == $past(flow_control_strap)
            && setup_a_r[SA_RX_FC] == $past(flow_control_strap);
    endproperty
    a_strap: assert property (@(posedge clk_sys) p_strap) else $error("strap not loaded");

    property p_speed;
        !srst && setup_b_r[SB_NOT_GIG] && !wr_commit && $stable(setup_a_r) |=> ##0
            speed_code == (setup_a_r[SA_SPEED_100] ? SPD_100 : SPD_10);
    endproperty
    a_speed: assert property (p_speed) else $error("10/100 speed mismatch");

    property p_gig;
        !srst && !setup_b_r[SB_NOT_GIG] && !wr_commit |=> speed_code == SPD_1000;
    endproperty
    a_gig: assert property (p_gig) else $error("gigabit not selected");

    property p_rxdly;
        !srst && !wr_commit |=> rx_clock_delay_enable == $past(setup_b_r[SB_RX_DLY]);
    endproperty
    a_rxdly: assert property (p_rxdly) else $error("rx delay enable mismatch");

    property p_txdly;
        // the decoded output holds its own reset default, so skip the reset edge
        !srst && !wr_commit |=> tx_clock_delay_enable == $past(setup_b_r[SB_TX_DLY]);
    endproperty
    a_txdly: assert property (p_txdly) else $error("tx delay enable mismatch");

    property p_role;
        !(mii_mac_role && mii_drive_clocks) && !(rmii_refclk_drive && mii_drive_clocks);
    endproperty
    a_role: assert property (p_role) else $error("clock role conflict");

    property p_bp;
        backpress_active |-> !duplex_full;
    endproperty
    a_bp: assert property (p_bp) else $error("back pressure at full duplex");

    property p_badfrm;
        frame_end && frame_bad && !(frame_is_fc && fc_filter_en) |=>
            fwd_mirror_only == $past(opt_b_r[OB_PASS_ALL]) && !fwd_normal
            && frame_drop == !$past(opt_b_r[OB_PASS_ALL]);
    endproperty
    a_badfrm: assert property (p_badfrm) else $error("bad frame verdict wrong");

    property p_fcfilt;
        frame_end && frame_is_fc && fc_filter_en |=> frame_drop && !fwd_mirror_only;
    endproperty
    a_fcfilt: assert property (p_fcfilt) else $error("flow control frame not filtered");

    property p_ro;
        setup_a_r[SA_PORT7_ID] == PORT7_ID && opt_a_r[7:4] == 4'h0 && !opt_a_r[2]
            && !opt_b_r[6];
    endproperty
    a_ro: assert property (p_ro) else $error("read-only bit changed");

    property p_apb;
        psel && penable && !pready |=> pready ##1 !pready;
    endproperty
    a_apb: assert property (p_apb) else $error("apb answer timing wrong");

    c_write: cover property (wr_commit && hit_setup_b);
    c_rderr: cover property (pready && pslverr);
    c_mirror: cover property (fwd_mirror_only);
    c_rmii_drive: cover property (rmii_refclk_drive);
endmodule

// ---- hdl/pmxcb_pkg.sv ----
// package: register map, field positions, reset values and timing constants
package pmxcb_pkg;
    // register indices as printed; byte address is four times the index
    localparam logic [11:0] IDX_SETUP_A = 12'h0300;
    localparam logic [11:0] IDX_SETUP_B = 12'h0301;
    localparam logic [11:0] IDX_OPT_A = 12'h0400;
    localparam logic [11:0] IDX_OPT_B = 12'h0401;
    localparam logic [13:0] ADDR_SETUP_A = {IDX_SETUP_A, 2'b00};
    localparam logic [13:0] ADDR_SETUP_B = {IDX_SETUP_B, 2'b00};
    localparam logic [13:0] ADDR_OPT_A = {IDX_OPT_A, 2'b00};
    localparam logic [13:0] ADDR_OPT_B = {IDX_OPT_B, 2'b00};
    // setup a fields
    localparam int SA_PORT7_ID = 7;
    localparam int SA_DUPLEX = 6;
    localparam int SA_TX_FC = 5;
    localparam int SA_SPEED_100 = 4;
    localparam int SA_RX_FC = 3;
    // setup b fields
    localparam int SB_NOT_GIG = 6;
    localparam int SB_RX_DLY = 4;
    localparam int SB_TX_DLY = 3;
    localparam int SB_ROLE = 2;
    localparam int SB_ITYPE_HI = 1;
    localparam int SB_ITYPE_LO = 0;
    // options fields
    localparam int OA_STORM = 1;
    localparam int OB_BACKPRESS = 3;
    localparam int OB_PASS_ALL = 0;
    // writable bit masks; cleared bits are fixed read-only values
    localparam logic [7:0] MASK_SETUP_A = 8'h7f;
    localparam logic [7:0] MASK_SETUP_B = 8'hff;
    localparam logic [7:0] MASK_OPT_A = 8'h0b;
    localparam logic [7:0] MASK_OPT_B = 8'hbf;
    // fixed reset values (strap bits are overlaid at reset)
    localparam logic [7:0] RST_SETUP_A = 8'h50;
    localparam logic [7:0] RST_SETUP_B = 8'h08;
    localparam logic [7:0] RST_OPT_A = 8'h00;
    localparam logic [7:0] RST_OPT_B = 8'h00;
    // interface type codes
    localparam logic [1:0] ITYPE_RGMII = 2'h0;
    localparam logic [1:0] ITYPE_RMII = 2'h1;
    // speed codes driven to the mac
    localparam logic [1:0] SPD_10 = 2'h0;
    localparam logic [1:0] SPD_100 = 2'h1;
    localparam logic [1:0] SPD_1000 = 2'h2;
    // clock delay: least delay in ps, and its count of 5 ns cycles rounded up
    localparam int CLK_PERIOD_PS = 5000;
    localparam int CLK_DELAY_MIN_PS = 1500;
    localparam int CLK_DELAY_CYC = (CLK_DELAY_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
endpackage

// ---- hdl/pmxcb_verdict.sv ----
// frame verdict: drop, forward, or forward to mirror ports only
`timescale 1ns/1ps
module pmxcb_verdict
    import pmxcb_pkg::*;
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic frame_end,
    input wire logic frame_bad,
    input wire logic frame_is_fc,
    input wire logic fc_filter_en,
    input wire logic pass_all,
    output logic verdict_valid_r,
    output logic fwd_normal_r,
    output logic fwd_mirror_only_r,
    output logic drop_r
);
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            verdict_valid_r <= 1'b0;
            fwd_normal_r <= 1'b0;
            fwd_mirror_only_r <= 1'b0;
            drop_r <= 1'b0;
        end else begin
            verdict_valid_r <= frame_end;
            fwd_normal_r <= 1'b0;
            fwd_mirror_only_r <= 1'b0;
            drop_r <= 1'b0;
            if (frame_end) begin
                // flow control filtering is decided before pass-all is looked at
                if (frame_is_fc && fc_filter_en) begin
                    drop_r <= 1'b1;
                end else if (frame_bad) begin
                    fwd_mirror_only_r <= pass_all;
                    drop_r <= !pass_all;
                end else begin
                    fwd_normal_r <= 1'b1;
                end
            end
        end
    end
endmodule

// ---- hdl/pmxcb_mode.sv ----
// media mode decode: speed, duplex, clock roles and clock delay enables
`timescale 1ns/1ps
module pmxcb_mode
    import pmxcb_pkg::*;
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic [7:0] setup_a,
    input wire logic [7:0] setup_b,
    input wire logic [7:0] opt_b,
    output logic [1:0] speed_code_r,
    output logic duplex_full_r,
    output logic backpress_active_r,
    output logic [1:0] interface_type_r,
    output logic mii_mac_role_r,
    output logic mii_drive_clocks_r,
    output logic rmii_refclk_drive_r,
    output logic rx_clock_delay_enable_r,
    output logic tx_clock_delay_enable_r
);
    logic is_mii;
    logic is_rmii;
    assign is_rmii = (setup_b[SB_ITYPE_HI:SB_ITYPE_LO] == ITYPE_RMII);
    assign is_mii = setup_b[SB_ITYPE_HI];

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            speed_code_r <= SPD_100;
            duplex_full_r <= 1'b1;
            backpress_active_r <= 1'b0;
            interface_type_r <= ITYPE_RGMII;
            mii_mac_role_r <= 1'b0;
            mii_drive_clocks_r <= 1'b0;
            rmii_refclk_drive_r <= 1'b0;
            rx_clock_delay_enable_r <= 1'b0;
            tx_clock_delay_enable_r <= 1'b0;
        end else begin
            if (!setup_b[SB_NOT_GIG]) begin
                speed_code_r <= SPD_1000;
            end else if (setup_a[SA_SPEED_100]) begin
                speed_code_r <= SPD_100;
            end else begin
                speed_code_r <= SPD_10;
            end
            duplex_full_r <= setup_a[SA_DUPLEX];
            backpress_active_r <= opt_b[OB_BACKPRESS] && !setup_a[SA_DUPLEX];
            interface_type_r <= setup_b[SB_ITYPE_HI:SB_ITYPE_LO];
            mii_mac_role_r <= is_mii && setup_b[SB_ROLE];
            mii_drive_clocks_r <= is_mii && !setup_b[SB_ROLE];
            rmii_refclk_drive_r <= is_rmii && !setup_b[SB_ROLE];
            // enables steer external delay cells of at least the least delay
            rx_clock_delay_enable_r <= setup_b[SB_RX_DLY];
            tx_clock_delay_enable_r <= setup_b[SB_TX_DLY];
        end
    end
endmodule

// ---- verification/pmxcb_partner.sv ----
// far-side media partner model: frame source and clock ownership
`timescale 1ns/1ps
module pmxcb_partner
    import pmxcb_pkg::*;
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic send,
    input wire logic want_bad,
    input wire logic want_fc,
    input wire logic mii_mac_role,
    input wire logic [1:0] interface_type,
    input wire logic rmii_refclk_drive,
    output logic frame_end,
    output logic frame_bad,
    output logic frame_is_fc,
    output logic partner_clk_on
);
    ////////////////////////////////////////////////////////////////////////////////
    logic junk_r;

    // qualifiers mean nothing outside frame_end; toggling them stops anything leaning on them
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            junk_r <= 1'b0;
        end else begin
            junk_r <= ~junk_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    assign frame_end = send;
    assign frame_bad = send ? want_bad : junk_r;
    assign frame_is_fc = send ? want_fc : ~junk_r;
    // partner supplies the clock only where the port leaves it to the far side
    assign partner_clk_on = mii_mac_role |
        ((interface_type == ITYPE_RMII) & ~rmii_refclk_drive);
endmodule

// ---- verification/pmxcb_bank_tb.sv ----
// self-checking testbench for the port media and switch mac configuration bank
`timescale 1ns/1ps
module pmxcb_bank_tb
    import pmxcb_pkg::*;
;
    typedef struct packed {logic [1:0] idx; logic [7:0] wd; logic [7:0] ex;} pmxcb_row_t;
    logic clk_sys, srst, psel, penable, pwrite, pready, pslverr;
    logic [13:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic flow_control_strap, speed_strap, clock_role_strap, err;
    logic [1:0] interface_type_strap, speed_code, interface_type;
    logic frame_end, frame_bad, frame_is_fc, fc_filter_en, send, want_bad, want_fc, partner_clk_on;
    logic duplex_full, tx_flow_ctrl_en, rx_flow_ctrl_en, mii_mac_role, mii_drive_clocks;
    logic rmii_refclk_drive, rx_clock_delay_enable, tx_clock_delay_enable, storm_protect_en;
    logic backpress_active, verdict_valid, fwd_normal, fwd_mirror_only, frame_drop;
    logic [13:0] out_vec;
    logic [7:0] sh [4];
    logic [13:0] reg_addr [4] = '{ADDR_SETUP_A, ADDR_SETUP_B, ADDR_OPT_A, ADDR_OPT_B};
    int bad_count = 0;
    int compares = 0;
    int cycles = 0;
    pmxcb_row_t rows [12] = '{'{2'h0, 8'h80, 8'h00}, '{2'h1, 8'h56, 8'h56}, '{2'h0, 8'h7f, 8'h7f},
        '{2'h1, 8'h03, 8'h03}, '{2'h1, 8'h01, 8'h01}, '{2'h1, 8'h05, 8'h05},
        '{2'h2, 8'hff, 8'h0b}, '{2'h3, 8'hff, 8'hbf}, '{2'h0, 8'h3f, 8'h3f},
        '{2'h2, 8'h00, 8'h00}, '{2'h1, 8'h00, 8'h00}, '{2'h3, 8'h40, 8'h00}};

    assign out_vec = {duplex_full, tx_flow_ctrl_en, rx_flow_ctrl_en, speed_code, interface_type,
        mii_mac_role, mii_drive_clocks, rmii_refclk_drive, rx_clock_delay_enable,
        tx_clock_delay_enable, storm_protect_en, backpress_active};

    pmxcb_bank #(.PORT_NUM(6), .ADDR_W(14)) dut (.*);
    pmxcb_partner partner (.*);

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            $display("timeout at t=%0t", $time);
            stop_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("counts: compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // holds the request until pready is seen high at a rising edge
    task automatic apb(input logic [13:0] a, input logic wr, input logic [7:0] wd,
                       output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= wr;
        pwdata <= {24'ha5_a5a5, wd};
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [13:0] exp_out();
        logic [1:0] spd;
        logic mii;
        spd = sh[1][6] ? (sh[0][4] ? SPD_100 : SPD_10) : SPD_1000;
        mii = sh[1][1];
        return {sh[0][6], sh[0][5], sh[0][3], spd, sh[1][1:0], mii & sh[1][2], mii & ~sh[1][2],
            (sh[1][1:0] == ITYPE_RMII) & ~sh[1][2], sh[1][4], sh[1][3], sh[2][1],
            sh[3][3] & ~sh[0][6]};
    endfunction

    // expected {valid, normal, mirror only, drop}; filtered flow control wins over pass-all
    function automatic logic [3:0] ev(input int f, input int p);
        if (f[1] & f[2]) return 4'h9;
        if (f[0]) return (p != 0) ? 4'ha : 4'h9;
        return 4'hc;
    endfunction

    task automatic check_all();
        logic [31:0] r;
        logic e;
        for (int i = 0; i < 4; i++) begin
            apb(reg_addr[i], 1'b0, 8'h00, r, e);
            chk(r, {24'h00_0000, sh[i]});
            chk(32'(e), 32'h0000_0000);
        end
        chk(32'(out_vec), 32'(exp_out()));
        chk(32'(partner_clk_on),
            32'((sh[1][1] | (sh[1][1:0] == ITYPE_RMII)) & sh[1][2]));
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        srst = 1'b1;
        {psel, penable, pwrite, send, want_bad, want_fc, fc_filter_en} = 7'h00;
        paddr = 14'h0000;
        pwdata = 32'h0000_0000;
        pstrb = 4'hf;
        {flow_control_strap, speed_strap, clock_role_strap} = 3'h6;
        interface_type_strap = ITYPE_RMII;
        repeat (10) @(posedge clk_sys);
        srst <= 1'b0;
        sh = '{8'h78, 8'h49, 8'h00, 8'h00};
        check_all();
        $display("test strap_reset_a done");
        for (int i = 0; i < 12; i++) begin
            apb(reg_addr[rows[i].idx], 1'b1, rows[i].wd, rd, err);
            sh[rows[i].idx] = rows[i].ex;
            check_all();
        end
        $display("test register_rows done");
        apb(14'h0c08, 1'b0, 8'h00, rd, err);
        chk({rd[31:1], err}, 32'h0000_0001);
        apb(14'h0c0c, 1'b1, 8'hff, rd, err);
        chk(32'(err), 32'h0000_0001);
        pstrb <= 4'h0;
        apb(ADDR_SETUP_B, 1'b1, 8'hff, rd, err);
        pstrb <= 4'hf;
        check_all();
        $display("test refused_writes done");
        for (int p = 0; p < 2; p++) begin
            apb(ADDR_OPT_B, 1'b1, {7'h00, p[0]}, rd, err);
            repeat (2) @(posedge clk_sys);
            for (int i = 0; i < 9; i++) begin
                @(posedge clk_sys);
                send <= (i < 8);
                want_bad <= i[0];
                want_fc <= i[1];
                fc_filter_en <= i[2];
                #1;
                if (i > 0) begin
                    chk(32'({verdict_valid, fwd_normal, fwd_mirror_only, frame_drop}),
                        32'(ev(i - 1, p)));
                end
            end
            @(posedge clk_sys);
            #1;
            chk(32'({verdict_valid, fwd_normal, fwd_mirror_only, frame_drop}), 32'h0000_0000);
        end
        $display("test frame_verdict done");
        @(posedge clk_sys);
        srst <= 1'b1;
        {flow_control_strap, speed_strap, clock_role_strap} <= 3'h1;
        interface_type_strap <= 2'h2;
        repeat (3) @(posedge clk_sys);
        srst <= 1'b0;
        sh = '{8'h50, 8'h0e, 8'h00, 8'h00};
        check_all();
        $display("test strap_reset_b done");
        stop_test();
    end
endmodule
